// File: design/msr_defs.svh
// register map, field positions, reset values and counts of the memory select and refresh block
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

`define MSR_OFS_REFRESH_WAIT 8'h1f
`define MSR_OFS_REFRESH_INTERVAL 8'h23
`define MSR_OFS_REFRESH_PENDING 8'h24
`define MSR_OFS_REFRESH_CONTROL 8'h25
`define MSR_OFS_RAM_LOW 8'h2e
`define MSR_OFS_RAM_UPPER 8'h2f
`define MSR_OFS_ROM_LOW 8'h30
`define MSR_OFS_ROM_UPPER 8'h31
`define MSR_OFS_ROM_MODE 8'h32
`define MSR_OFS_RAM_MODE 8'hd3

`define MSR_RST_REFRESH_WAIT 8'hff
`define MSR_RST_REFRESH_INTERVAL 8'h00
`define MSR_RST_REFRESH_CONTROL 8'h00
`define MSR_RST_RAM_LOW 8'h0f
`define MSR_RST_RAM_UPPER 8'h00
`define MSR_RST_ROM_LOW 8'h08
`define MSR_RST_ROM_UPPER 8'h00
`define MSR_RST_MODE 8'hff

`define MSR_SIZE_RNG 3:0
`define MSR_LOWBASE_RNG 7:4
`define MSR_ADDR_UP_RNG 23:16
`define MSR_ADDR_LO_RNG 15:12
`define MSR_ADDR_CMP_RNG 23:12
`define MSR_SEL_ENABLE_BIT 7
`define MSR_REF_ENABLE_BIT 7
`define MSR_BURST_RNG 5:0
`define MSR_T1_RNG 7:5
`define MSR_T2_RNG 4:3
`define MSR_T3_RNG 2:0

`define MSR_SIZE_LAST 4'hb
`define MSR_SIZE_ALL 4'hf
`define MSR_CMP_LINES 12
`define MSR_PEND_MAX 8'hff
`define MSR_INTERVAL_ZERO_CYCLES 10'h3ff
`define MSR_INTERVAL_SHIFT 2
`define MSR_BURST_ZERO_LEN 7'h40

`endif

// File: design/msr_pkg.sv
// types shared by the memory select and refresh block
package msr_pkg;
  typedef struct packed {
    logic [2:0] t1;
    logic [1:0] t2;
    logic [2:0] t3;
  } msr_wait_t;
  typedef struct packed {
    logic valid;
    logic [6:0] burst_len;
    msr_wait_t waits;
  } msr_refresh_req_t;
  typedef struct packed {
    logic write;
    logic [7:0] data;
  } msr_load_t;
endpackage

// File: design/msr_refresh.sv
// refresh request timer and pending request counter
`timescale 1ns/10ps
`include "msr_defs.svh"
module msr_refresh #(
  parameter int PEND_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [7:0] interval,
  input wire msr_pkg::msr_load_t pend_load,
  input wire logic burst_done,
  output logic request_tick,
  output logic [PEND_W-1:0] pending
);
  import msr_pkg::*;

  generate
    if (PEND_W != 8)
    begin : g_bad_width
      $error("msr_refresh supports only an 8-bit pending counter");
    end
  endgenerate

  logic [9:0] interval_count;
  logic [9:0] next_reload;

  function automatic logic [9:0] reload_of(input logic [7:0] n);
    if (n == 8'h00)
    begin
      reload_of = `MSR_INTERVAL_ZERO_CYCLES;
    end
    else
    begin
      reload_of = 10'({n, 2'b00} - 10'h001);
    end
  endfunction

  always_comb
  begin
    next_reload = reload_of(interval);
  end

  // counts 4*n cycles, or 1024 for n = 0, only while enabled
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      interval_count <= `MSR_INTERVAL_ZERO_CYCLES;
      request_tick <= 1'b0;
    end
    else if (!enable)
    begin
      interval_count <= next_reload;
      request_tick <= 1'b0;
    end
    else if (interval_count == 10'h000)
    begin
      interval_count <= next_reload;
      request_tick <= 1'b1;
    end
    else
    begin
      interval_count <= interval_count - 10'h001;
      request_tick <= 1'b0;
    end
  end

  // a software load is taken first, then the hardware step is applied on top
  logic [7:0] base;
  logic inc;
  logic dec;
  always_comb
  begin
    base = pend_load.write ? pend_load.data : pending;
    inc = request_tick && (base != `MSR_PEND_MAX);
    dec = burst_done && (base != 8'h00);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pending <= 8'h00;
    end
    else if (!enable)
    begin
      pending <= 8'h00;
    end
    else if (inc && !dec)
    begin
      pending <= base + 8'h01;
    end
    else if (dec && !inc)
    begin
      pending <= base - 8'h01;
    end
    else
    begin
      pending <= base;
    end
  end
endmodule

// File: design/msr_top.sv
// memory chip select decoder with refresh request generator and register port
// Behaviour
// - both windows compare the upper base byte with A[23:16] and the low base nibble with A[15:12].
// - the size code is bits 3:0 of the low base register and the low base nibble is bits 7:4.
// - size codes 0 to 11 compare A[23] only up to A[23:12], one more line per code.
// - ram size code 1111 selects ram for every address not selected by rom.
// - a refresh request is issued every 4*n clocks, with n = 0 giving 1024 clocks.
// - refresh requests are made only while the refresh enable bit 7 is set.
// - the pending count steps up per request, stops at 255 and drops further requests.
// - the pending count steps down per finished refresh burst.
// - while refresh is disabled the pending count is held at zero and stays readable.
// - the burst field gives 1 to 64 transactions per request, zero meaning 64.
// - refresh transactions carry 0 to 7 t1 waits from wait register bits 7:5.
// - refresh transactions carry 0 to 3 t2 waits from wait register bits 4:3.
// - refresh transactions carry 0 to 7 t3 waits from wait register bits 2:0.
// - rom select asserts on a match only while the rom select enable bit is set.
// - ram select asserts on a match only while the ram select enable bit is set.
`timescale 1ns/10ps
`include "msr_defs.svh"
module msr_top #(
  parameter int ADDR_W = 24,
  parameter int REG_ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [ADDR_W-1:0] proc_addr,
  output logic ram_select_n,
  output logic rom_select_n,
  output msr_pkg::msr_refresh_req_t refresh_req,
  output logic refresh_tick,
  input wire logic refresh_burst_done
);
  import msr_pkg::*;

  generate
    if (ADDR_W != 24 || REG_ADDR_W != 8)
    begin : g_bad_param
      $error("msr_top needs a 24-bit address bus and an 8-bit register address");
    end
  endgenerate

  logic [7:0] refresh_wait;
  logic [7:0] refresh_interval;
  logic [7:0] refresh_control;
  logic [7:0] refresh_pending_count;
  logic [7:0] ram_base_low_size;
  logic [7:0] ram_base_upper;
  logic [7:0] rom_base_low_size;
  logic [7:0] rom_base_upper;
  logic [7:0] rom_mode;
  logic [7:0] ram_mode;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = we && hit(a, ofs);
  endfunction

  // mask over A[23:12]; code k keeps the top k+1 lines
  function automatic logic [11:0] cmp_mask(input logic [3:0] code);
    logic [11:0] m;
    m = 12'h000;
    for (int i = 0; i < `MSR_CMP_LINES; i++)
    begin
      if (i >= (`MSR_CMP_LINES - 1 - int'(code)))
      begin
        m[i] = 1'b1;
      end
    end
    cmp_mask = m;
  endfunction

  // reserved codes never match; their behaviour is left open to software
  function automatic logic window_match(
    input logic [23:0] a,
    input logic [7:0] upper,
    input logic [7:0] low_size
  );
    logic [11:0] base;
    logic [11:0] diff;
    base = {upper, low_size[`MSR_LOWBASE_RNG]};
    diff = (a[`MSR_ADDR_CMP_RNG] ^ base) & cmp_mask(low_size[`MSR_SIZE_RNG]);
    if (low_size[`MSR_SIZE_RNG] > `MSR_SIZE_LAST)
    begin
      window_match = 1'b0;
    end
    else
    begin
      window_match = (diff == 12'h000);
    end
  endfunction

  // refresh wait register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      refresh_wait <= `MSR_RST_REFRESH_WAIT;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_REFRESH_WAIT))
    begin
      refresh_wait <= reg_wdata;
    end
  end

  // refresh interval register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      refresh_interval <= `MSR_RST_REFRESH_INTERVAL;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_REFRESH_INTERVAL))
    begin
      refresh_interval <= reg_wdata;
    end
  end

  // refresh control; bit 6 is not stored and reads as zero
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      refresh_control <= `MSR_RST_REFRESH_CONTROL;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_REFRESH_CONTROL))
    begin
      refresh_control <= {reg_wdata[`MSR_REF_ENABLE_BIT], 1'b0, reg_wdata[`MSR_BURST_RNG]};
    end
  end

  // ram window low base and size
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_base_low_size <= `MSR_RST_RAM_LOW;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_RAM_LOW))
    begin
      ram_base_low_size <= reg_wdata;
    end
  end

  // ram window upper base
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_base_upper <= `MSR_RST_RAM_UPPER;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_RAM_UPPER))
    begin
      ram_base_upper <= reg_wdata;
    end
  end

  // rom window low base and size
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_base_low_size <= `MSR_RST_ROM_LOW;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_ROM_LOW))
    begin
      rom_base_low_size <= reg_wdata;
    end
  end

  // rom window upper base
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_base_upper <= `MSR_RST_ROM_UPPER;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_ROM_UPPER))
    begin
      rom_base_upper <= reg_wdata;
    end
  end

  // rom mode register; only bit 7 steers this block, the rest is kept for software
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_mode <= `MSR_RST_MODE;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_ROM_MODE))
    begin
      rom_mode <= reg_wdata;
    end
  end

  // ram mode register; same split between bit 7 and software bits
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_mode <= `MSR_RST_MODE;
    end
    else if (wr_hit(reg_write, reg_addr, `MSR_OFS_RAM_MODE))
    begin
      ram_mode <= reg_wdata;
    end
  end

  // chip select decode, registered so the pins never glitch
  logic rom_hit;
  logic ram_hit;
  logic next_rom_sel;
  logic next_ram_sel;

  always_comb
  begin
    rom_hit = window_match(proc_addr, rom_base_upper, rom_base_low_size);
    ram_hit = window_match(proc_addr, ram_base_upper, ram_base_low_size);
    next_rom_sel = rom_mode[`MSR_SEL_ENABLE_BIT] && rom_hit;
    if (ram_base_low_size[`MSR_SIZE_RNG] == `MSR_SIZE_ALL)
    begin
      next_ram_sel = ram_mode[`MSR_SEL_ENABLE_BIT] && !next_rom_sel;
    end
    else
    begin
      next_ram_sel = ram_mode[`MSR_SEL_ENABLE_BIT] && ram_hit;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rom_select_n <= 1'b1;
      ram_select_n <= 1'b1;
    end
    else
    begin
      rom_select_n <= !next_rom_sel;
      ram_select_n <= !next_ram_sel;
    end
  end

  // refresh generator
  msr_load_t pend_load;
  logic refresh_enable;

  always_comb
  begin
    refresh_enable = refresh_control[`MSR_REF_ENABLE_BIT];
    pend_load.write = wr_hit(reg_write, reg_addr, `MSR_OFS_REFRESH_PENDING);
    pend_load.data = reg_wdata;
  end

  msr_refresh #(
    .PEND_W(8)
  ) u_refresh (
    .mclk(mclk),
    .nrst(nrst),
    .enable(refresh_enable),
    .interval(refresh_interval),
    .pend_load(pend_load),
    .burst_done(refresh_burst_done),
    .request_tick(refresh_tick),
    .pending(refresh_pending_count)
  );

  // burst description towards the external bus logic
  logic [6:0] next_burst_len;

  always_comb
  begin
    if (refresh_control[`MSR_BURST_RNG] == 6'h00)
    begin
      next_burst_len = `MSR_BURST_ZERO_LEN;
    end
    else
    begin
      next_burst_len = {1'b0, refresh_control[`MSR_BURST_RNG]};
    end
  end

  // valid stands while any request is pending; lags the counter by one cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      refresh_req <= '0;
    end
    else
    begin
      refresh_req.valid <= refresh_enable && (refresh_pending_count != 8'h00);
      refresh_req.burst_len <= next_burst_len;
      refresh_req.waits.t1 <= refresh_wait[`MSR_T1_RNG];
      refresh_req.waits.t2 <= refresh_wait[`MSR_T2_RNG];
      refresh_req.waits.t3 <= refresh_wait[`MSR_T3_RNG];
    end
  end

  // read port: data in the cycle after the strobe, zero otherwise
  logic [7:0] next_rdata;

  always_comb
  begin
    case (reg_addr)
      `MSR_OFS_REFRESH_WAIT: next_rdata = refresh_wait;
      `MSR_OFS_REFRESH_INTERVAL: next_rdata = refresh_interval;
      `MSR_OFS_REFRESH_PENDING: next_rdata = refresh_pending_count;
      `MSR_OFS_REFRESH_CONTROL: next_rdata = refresh_control;
      `MSR_OFS_RAM_LOW: next_rdata = ram_base_low_size;
      `MSR_OFS_RAM_UPPER: next_rdata = ram_base_upper;
      `MSR_OFS_ROM_LOW: next_rdata = rom_base_low_size;
      `MSR_OFS_ROM_UPPER: next_rdata = rom_base_upper;
      `MSR_OFS_ROM_MODE: next_rdata = rom_mode;
      `MSR_OFS_RAM_MODE: next_rdata = ram_mode;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_read)
    begin
      reg_rdata <= next_rdata;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// File: bench/msr_checker_assertions.sv
// port checker of the memory select and refresh block
`timescale 1ns/10ps
module msr_checker #(
  parameter int ADDR_W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [ADDR_W-1:0] proc_addr,
  input wire logic ram_select_n,
  input wire logic rom_select_n,
  input wire msr_pkg::msr_refresh_req_t refresh_req,
  input wire logic refresh_tick,
  input wire logic refresh_burst_done
);
  import msr_pkg::*;
  logic [7:0] r [256];
  logic [7:0] wq, cq;
  logic [2:0] eh;
  logic [10:0] gap, per;
  logic seen, rom_q, ram_q, rom_h, cfg_wr, cfg_wr_q;
  // a write on the reload edge leaves one period at the old length
  assign cfg_wr = reg_write && (reg_addr == 8'h23 || reg_addr == 8'h25);
  // reserved size codes give no match
  function automatic logic hit(logic [23:0] a, logic [7:0] u, logic [7:0] l);
    logic [11:0] m;
    m = 12'hfff << (4'hb - l[3:0]);
    return l[3:0] <= 4'hb && ((a[23:12] ^ {u, l[7:4]}) & m) == 12'h0;
  endfunction
  assign rom_h = r[8'h32][7] && hit(proc_addr[23:0], r[8'h31], r[8'h30]);
  assign per = r[8'h23] == 8'h0 ? 11'h400 : {1'b0, r[8'h23], 2'h0};
  // shadow registers; wq and cq lag one edge so the output register settles first
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 256; i++)
        r[i] <= 8'h0;
      r[8'h1f] <= 8'hff;
      r[8'h2e] <= 8'h0f;
      r[8'h30] <= 8'h08;
      r[8'h32] <= 8'hff;
      r[8'hd3] <= 8'hff;
      wq <= 8'h0;
      cq <= 8'hff;
      eh <= 3'h0;
      gap <= 11'h0;
      seen <= 1'b0;
      cfg_wr_q <= 1'b0;
      rom_q <= 1'b0;
      ram_q <= 1'b0;
    end
    else
    begin
      if (reg_write)
        r[reg_addr] <= reg_wdata;
      wq <= r[8'h1f];
      cq <= r[8'h25];
      eh <= {eh[1:0], r[8'h25][7]};
      gap <= refresh_tick ? 11'h0 : gap + 11'h1;
      cfg_wr_q <= cfg_wr;
      seen <= (seen || refresh_tick) && !cfg_wr && !cfg_wr_q;
      rom_q <= rom_h;
      ram_q <= r[8'hd3][7] && (r[8'h2e][3:0] == 4'hf ? !rom_h : hit(proc_addr[23:0], r[8'h2f], r[8'h2e]));
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_wait_fields: assert property (r[8'h1f] == wq |-> refresh_req.waits == wq)
    else $error("refresh waits differ");
  a_burst_len: assert property (r[8'h25] == cq |-> refresh_req.burst_len == (cq[5:0] == 6'h0 ? 7'h40 : {1'b0, cq[5:0]}))
    else $error("burst length differs");
  a_tick_off: assert property (!(|eh) && !r[8'h25][7] |-> !refresh_tick)
    else $error("tick while disabled");
  a_valid_off: assert property (!(|eh) && !r[8'h25][7] |-> !refresh_req.valid)
    else $error("request while disabled");
  a_tick_period: assert property (refresh_tick && seen |-> gap + 11'h1 == per)
    else $error("tick period wrong");
  a_tick_valid: assert property (refresh_tick && !refresh_burst_done && r[8'h25][7] && !reg_write ##1 !reg_write |-> ##1 refresh_req.valid)
    else $error("tick not counted");
  a_rom_decode: assert property (rom_select_n == !rom_q)
    else $error("rom select wrong");
  a_ram_decode: assert property (ram_select_n == !ram_q)
    else $error("ram select wrong");
  c_tick: cover property (refresh_tick);
  c_done: cover property (refresh_burst_done ##1 !refresh_burst_done);
  c_rom: cover property ($fell(rom_select_n));
endmodule
bind msr_top msr_checker #(.ADDR_W(ADDR_W)) i_msr_checker (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_write,
  .proc_addr, .ram_select_n, .rom_select_n, .refresh_req, .refresh_tick, .refresh_burst_done);

// File: bench/msr_ext_bus.sv
// external bus logic model that runs refresh bursts
`timescale 1ns/10ps
module msr_ext_bus (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hold,
  input wire logic slow,
  input wire msr_pkg::msr_refresh_req_t refresh_req,
  output logic burst_done
);
  import msr_pkg::*;
  logic [9:0] left;
  logic [1:0] gap;
  // gap waits out the lag of valid behind the pending count
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      left <= 10'h0;
      gap <= 2'h0;
      burst_done <= 1'b0;
    end
    else
    begin
      burst_done <= left == 10'h1;
      if (left == 10'h1)
        gap <= 2'h3;
      else if (gap != 2'h0)
        gap <= gap - 2'h1;
      if (left != 10'h0)
        left <= left - 10'h1;
      else if (refresh_req.valid && gap == 2'h0 && !hold)
        left <= slow ? {refresh_req.burst_len, 3'h0} : {3'h0, refresh_req.burst_len};
    end
  end
endmodule

// File: bench/msr_top_tb_top.sv
// self-checking bench of the memory select and refresh block
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module msr_top_tb_top;
  import msr_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [7:0] reg_wdata = 8'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [23:0] proc_addr = 24'h0;
  logic ram_select_n, rom_select_n, refresh_tick;
  logic refresh_burst_done;
  logic hold = 1'b1;
  logic slow = 1'b0;
  msr_refresh_req_t refresh_req;
  int n_fail = 0;
  int total_checks = 0;
  int k;
  logic [7:0] ta [11] = '{8'h1f, 8'h23, 8'h24, 8'h25, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'hd3, 8'h40};
  logic [7:0] tv [11] = '{8'hff, 8'h0, 8'h0, 8'h0, 8'h0f, 8'h0, 8'h08, 8'h0, 8'hff, 8'hff, 8'h0};
  always #2 mclk = ~mclk;
  msr_top i_msr_top (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .proc_addr,
    .ram_select_n, .rom_select_n, .refresh_req, .refresh_tick, .refresh_burst_done);
  msr_ext_bus i_msr_ext_bus (.mclk, .nrst, .hold, .slow, .refresh_req, .burst_done(refresh_burst_done));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic sel(input logic [23:0] a, input logic ro, input logic ra);
    @(posedge mclk);
    proc_addr <= a;
    @(posedge mclk);
    #1;
    `CHK(rom_select_n, ro)
    `CHK(ram_select_n, ra)
  endtask
  task automatic tk(output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (!refresh_tick && n < 2000);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #40us;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(ta[i], tv[i]);
    wr(8'h40, 8'h5a);
    wr(8'h25, 8'h7f);
    rd(8'h40, 8'h0);
    rd(8'h25, 8'h3f);
    wr(8'h25, 8'h0);
    $display("test registers done");
    wr(8'h31, 8'h12);
    for (int s = 0; s < 12; s++)
    begin
      wr(8'h30, {4'h3, s[3:0]});
      sel(24'h123000 ^ (24'h1 << (22 - s)), 1'b0, 1'b1);
      sel(24'h123000 ^ (24'h1 << (23 - s)), 1'b1, 1'b0);
    end
    wr(8'h32, 8'h7f);
    sel(24'h123000, 1'b1, 1'b0);
    wr(8'h2f, 8'h40);
    wr(8'h2e, 8'h57);
    sel(24'h40ffff, 1'b1, 1'b0);
    sel(24'h41ffff, 1'b1, 1'b1);
    wr(8'hd3, 8'h7f);
    sel(24'h40ffff, 1'b1, 1'b1);
    $display("test selects done");
    wr(8'h1f, 8'hb5);
    wr(8'h25, 8'h80);
    tk(k);
    `CHK(k, 1024)
    rd(8'h24, 8'h1);
    `CHK(refresh_req, {1'b1, 7'h40, 8'hb5})
    wr(8'h23, 8'h1);
    wr(8'h25, 8'h0);
    wr(8'h25, 8'h81);
    wr(8'h24, 8'hfe);
    repeat (12) @(posedge mclk);
    rd(8'h24, 8'hff);
    tk(k);
    tk(k);
    `CHK(k, 4)
    wr(8'h23, 8'h40);
    wr(8'h25, 8'h0);
    slow <= 1'b1;
    hold <= 1'b0;
    wr(8'h25, 8'h81);
    wr(8'h24, 8'h3);
    #1;
    `CHK(refresh_req.burst_len, 7'h1)
    repeat (150) @(posedge mclk);
    hold <= 1'b1;
    rd(8'h24, 8'h0);
    $display("test refresh done");
    wr(8'h24, 8'h9);
    wr(8'h25, 8'h1);
    wr(8'h24, 8'h7);
    rd(8'h24, 8'h0);
    k = 0;
    repeat (1100)
    begin
      @(posedge mclk);
      #1;
      k += int'(refresh_tick !== 1'b0);
    end
    `CHK(k, 0)
    `CHK(refresh_req.valid, 1'b0)
    $display("test disable done");
    summarize();
  end
endmodule
